/* logic/pho_pkg.sv */
/*
  holdover controller constants, register map, field layouts, carriers.
  assumes one 20 MHz clock faster than the first loop's compare rate.
*/
// Behaviour
// R1: host sets holdover enable before any entry
// R2: tracked mode drives tracked code in holdover
// R3: tracker acquired flag, routable to status pins
// R4: tracker updates every multiplier times counter cycles
// R5: host keeps update rate at most 100 kHz
// R6: present tracker code readable by software
// R7: charge pump high impedance during holdover
// R8: holdover drops first lock, raises holdover status
// R9: second lock held if locked at entry
// R10: holdover output fixed code or last tracked
// R11: lock detection keeps running during holdover
// R12: holdover status routable to either status pin
// R13: holdover ends by host or automatically
// R14: auto exit uses window and holdover count
// R15: auto exit needs phase error under window
// R16: fixed select overrides tracked value at entry
// R17: acquired means within two codes of tuning
// R18: lock count up inside window, clear outside
// R19: enter on reference loss, freeze tracking
package pho_pkg;
  // ==========================================
  // widths
  localparam int DAC_W = 10;
  localparam int PERR_W = 8;
  localparam int MULT_W = 15;
  localparam int CNTR_W = 8;
  localparam int LCNT_W = 14;
  localparam int ADR_W = 8;
  // ==========================================
  // register byte offsets
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_FIXED = 8'h04;
  localparam logic [ADR_W-1:0] OFS_RATE = 8'h08;
  localparam logic [ADR_W-1:0] OFS_WINDOW = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_COUNT = 8'h10;
  localparam logic [ADR_W-1:0] OFS_SELECT = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADR_W-1:0] OFS_IRQ = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_MASK = 8'h20;
  // ==========================================
  // field positions
  localparam int RATE_CNTR_LSB = 16;
  localparam int COUNT_HOLD_LSB = 16;
  localparam int SEL_TWO_LSB = 8;
  localparam int ST_HOLD = 0;
  localparam int ST_LOCK1 = 1;
  localparam int ST_LOCK2 = 2;
  localparam int ST_ACQ = 3;
  localparam int ST_RATE_WARN = 4;
  localparam int ST_CODE_LSB = 16;
  // ==========================================
  // status pin source choices
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_LOCK1 = 3'h1;
  localparam logic [2:0] SEL_LOCK2 = 3'h2;
  localparam logic [2:0] SEL_BOTH = 3'h3;
  localparam logic [2:0] SEL_HOLD = 3'h4;
  localparam logic [2:0] SEL_ACQ = 3'h5;
  // ==========================================
  // reset values and limits
  localparam logic [MULT_W-1:0] MULT_RST = 15'h00C8;
  localparam logic [CNTR_W-1:0] CNTR_RST = 8'h01;
  localparam logic [PERR_W-1:0] WINDOW_RST = 8'h10;
  localparam logic [LCNT_W-1:0] LCNT_RST = 14'h0010;
  localparam int ACQ_TOL = 2;
  localparam int CLK_HZ = 20_000_000;
  localparam int MAX_UPDATE_HZ = 100_000;
  localparam int MIN_UPDATE_CYC = CLK_HZ / MAX_UPDATE_HZ;
  // ==========================================
  // carriers
  typedef struct packed {
    logic auto_exit;
    logic exit_req;
    logic fixed_sel;
    logic track_en;
    logic hold_en;
  } pho_ctrl_t;
  typedef struct packed {
    logic lock_lost;
    logic tracker_acq;
    logic hold_exit;
    logic hold_entry;
  } pho_irq_t;
  localparam pho_ctrl_t CTRL_RST = 5'h00;
  localparam pho_irq_t IRQ_RST = 4'h0;
  typedef enum logic {PHO_TRACK, PHO_HOLD} pho_state_t;
endpackage : pho_pkg

/* logic/pho_holdover_ctrl.sv */
/*
  holdover controller for the first loop: tracker, lock detect,
  holdover state, status pins, wishbone registers and interrupt.
  assumes pin inputs are asynchronous and come from the analog side;
  phase error is stable around its compare strobe.
*/
// The address map and the Wishbone slave port are this design's own decisions.
module pho_holdover_ctrl #(
  parameter int DAC_W = pho_pkg::DAC_W,
  parameter int PERR_W = pho_pkg::PERR_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [pho_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_ref_valid,
  input wire logic i_compare_strobe,
  input wire logic [PERR_W-1:0] i_phase_error,
  input wire logic i_second_loop_lock,
  input wire logic [DAC_W-1:0] i_tune_code,
  output logic o_cp_drive_en,
  output logic o_dac_drive_en,
  output logic [DAC_W-1:0] o_first_loop_tuning_output,
  output logic o_status_pin_one,
  output logic o_status_pin_two,
  output logic o_first_loop_lock,
  output logic o_second_loop_lock,
  output logic o_holdover,
  output logic o_tracker_acquired,
  output logic o_irq
);
  import pho_pkg::*;

  // ==========================================
  // parameter checks
  if (DAC_W < 3 || DAC_W > 16) begin : g_bad_dac
    $error("DAC_W must lie in 3..16");
  end
  if (PERR_W < 1 || PERR_W > 8) begin : g_bad_perr
    $error("PERR_W must lie in 1..8");
  end

  localparam int PIN_W = 3 + PERR_W + DAC_W;
  localparam int PROD_W = MULT_W + CNTR_W;
  localparam logic [PROD_W-1:0] MIN_CYC = PROD_W'(MIN_UPDATE_CYC);
  localparam logic [DAC_W-1:0] TOL = DAC_W'(ACQ_TOL);

  // ==========================================
  // helpers
  // byte-lane merge of a write into a word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // status pin source decode, shared by both pins
  function automatic logic pin_source(
    input logic [2:0] sel,
    input logic lock1,
    input logic lock2,
    input logic hold,
    input logic acq
  );
    case (sel)
      SEL_LOCK1: pin_source = lock1;
      SEL_LOCK2: pin_source = lock2;
      SEL_BOTH: pin_source = lock1 & lock2;
      SEL_HOLD: pin_source = hold; // R12
      SEL_ACQ: pin_source = acq; // R3
      default: pin_source = 1'b0;
    endcase
  endfunction : pin_source

  // ==========================================
  // pin synchronisers
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic strobe_dly;
  logic ref_s;
  logic strobe_s;
  logic lock2_s;
  logic [PERR_W-1:0] perr_s;
  logic [DAC_W-1:0] tune_s;

  // two stages; only the second stage is read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
      strobe_dly <= 1'b0;
    end else begin
      pin_meta <= {i_ref_valid, i_compare_strobe, i_second_loop_lock,
                   i_phase_error, i_tune_code};
      pin_sync <= pin_meta;
      strobe_dly <= strobe_s;
    end
  end

  assign {ref_s, strobe_s, lock2_s, perr_s, tune_s} = pin_sync;

  // ==========================================
  // register file
  pho_ctrl_t ctrl;
  logic [DAC_W-1:0] fixed_code;
  logic [MULT_W-1:0] rate_mult;
  logic [CNTR_W-1:0] rate_cntr;
  logic [PERR_W-1:0] lock_window;
  logic [LCNT_W-1:0] run_count;
  logic [LCNT_W-1:0] hold_count;
  logic [2:0] sel_one;
  logic [2:0] sel_two;
  pho_irq_t irq_mask;
  pho_irq_t irq_stat;
  logic manual_exit;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;

  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

  // ==========================================
  // holdover state and tracker signals
  pho_state_t state;
  pho_state_t next_state;
  logic enter_hold;
  logic leave_hold;
  logic [DAC_W-1:0] tracker_code;
  logic [DAC_W-1:0] held_code;
  logic tracker_acq;
  logic lock_raw;
  logic lock2_held;
  logic rate_warn;

  // byte lanes merged over the present word; the clear register over zero
  assign wr_word = lane_merge((i_wb_adr == OFS_IRQ) ? 32'h0 : rd_mux, i_wb_dat, i_wb_sel);

  // read decode; unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    case (i_wb_adr)
      OFS_CTRL: rd_mux = 32'({ctrl.auto_exit, 1'b0, ctrl.fixed_sel,
                              ctrl.track_en, ctrl.hold_en});
      OFS_FIXED: rd_mux = 32'(fixed_code);
      OFS_RATE: begin
        rd_mux[MULT_W-1:0] = rate_mult;
        rd_mux[RATE_CNTR_LSB +: CNTR_W] = rate_cntr;
      end
      OFS_WINDOW: rd_mux = 32'(lock_window);
      OFS_COUNT: begin
        rd_mux[LCNT_W-1:0] = run_count;
        rd_mux[COUNT_HOLD_LSB +: LCNT_W] = hold_count;
      end
      OFS_SELECT: begin
        rd_mux[2:0] = sel_one;
        rd_mux[SEL_TWO_LSB +: 3] = sel_two;
      end
      OFS_STATUS: begin
        rd_mux[ST_HOLD] = o_holdover;
        rd_mux[ST_LOCK1] = o_first_loop_lock;
        rd_mux[ST_LOCK2] = o_second_loop_lock;
        rd_mux[ST_ACQ] = tracker_acq;
        rd_mux[ST_RATE_WARN] = rate_warn;
        rd_mux[ST_CODE_LSB +: DAC_W] = tracker_code; // R6
      end
      OFS_IRQ: rd_mux = 32'(irq_stat);
      OFS_MASK: rd_mux = 32'(irq_mask);
      default: rd_mux = '0;
    endcase
  end

  // bus answer one cycle after the request, ack dropped after one
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req) begin
        o_wb_dat <= rd_mux;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= CTRL_RST;
      fixed_code <= '0;
      rate_mult <= MULT_RST;
      rate_cntr <= CNTR_RST;
      lock_window <= WINDOW_RST[PERR_W-1:0];
      run_count <= LCNT_RST;
      hold_count <= LCNT_RST;
      sel_one <= SEL_LOW;
      sel_two <= SEL_LOW;
      irq_mask <= IRQ_RST;
    end else if (bus_wr) begin
      case (i_wb_adr)
        OFS_CTRL: ctrl <= pho_ctrl_t'({wr_word[4], 1'b0, wr_word[2:0]});
        OFS_FIXED: fixed_code <= wr_word[DAC_W-1:0];
        OFS_RATE: begin
          rate_mult <= wr_word[MULT_W-1:0];
          rate_cntr <= wr_word[RATE_CNTR_LSB +: CNTR_W];
        end
        OFS_WINDOW: lock_window <= wr_word[PERR_W-1:0];
        OFS_COUNT: begin
          run_count <= wr_word[LCNT_W-1:0];
          hold_count <= wr_word[COUNT_HOLD_LSB +: LCNT_W];
        end
        OFS_SELECT: begin
          sel_one <= wr_word[2:0];
          sel_two <= wr_word[SEL_TWO_LSB +: 3];
        end
        OFS_MASK: irq_mask <= pho_irq_t'(wr_word[3:0]);
        default: ;
      endcase
    end
  end

  // exit request bit is a pulse, never stored
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      manual_exit <= 1'b0;
    end else begin
      manual_exit <= bus_wr && (i_wb_adr == OFS_CTRL) && wr_word[3]; // R13
    end
  end

  // ==========================================
  // tracker update tick: multiplier times counter cycles
  logic [MULT_W-1:0] mult_eff;
  logic [CNTR_W-1:0] cntr_eff;
  logic [MULT_W-1:0] mult_cnt;
  logic [CNTR_W-1:0] cntr_cnt;
  logic upd_tick;
  logic [PROD_W-1:0] period;

  // zero settings behave as one, so the tick never stalls
  assign mult_eff = (rate_mult == '0) ? MULT_W'(1) : rate_mult;
  assign cntr_eff = (rate_cntr == '0) ? CNTR_W'(1) : rate_cntr;
  assign period = PROD_W'(mult_eff) * PROD_W'(cntr_eff);
  assign rate_warn = period < MIN_CYC; // R5

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mult_cnt <= '0;
      cntr_cnt <= '0;
      upd_tick <= 1'b0;
    end else begin
      upd_tick <= 1'b0;
      if (mult_cnt >= mult_eff - MULT_W'(1)) begin // R4
        mult_cnt <= '0;
        if (cntr_cnt >= cntr_eff - CNTR_W'(1)) begin
          cntr_cnt <= '0;
          upd_tick <= 1'b1;
        end else begin
          cntr_cnt <= cntr_cnt + CNTR_W'(1);
        end
      end else begin
        mult_cnt <= mult_cnt + MULT_W'(1);
      end
    end
  end

  // ==========================================
  // tracker: one code step per update, frozen in holdover
  // slow slew is the price of a look-back that ignores glitches
  logic [DAC_W-1:0] diff;
  assign diff = (tracker_code > tune_s) ? tracker_code - tune_s
                                        : tune_s - tracker_code;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tracker_code <= '0;
    end else if (upd_tick && ctrl.track_en && state == PHO_TRACK) begin // R19
      if (tracker_code < tune_s) begin
        tracker_code <= tracker_code + DAC_W'(1);
      end else if (tracker_code > tune_s) begin
        tracker_code <= tracker_code - DAC_W'(1);
      end
    end
  end

  // acquired once within tolerance; held through holdover while tracking stays enabled
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tracker_acq <= 1'b0;
    end else if (!ctrl.track_en) begin
      tracker_acq <= 1'b0;
    end else if (state == PHO_TRACK) begin
      tracker_acq <= diff <= TOL; // R17
    end
  end

  // ==========================================
  // lock detect, also running in holdover for auto exit
  logic [LCNT_W-1:0] lock_cnt;
  logic [LCNT_W-1:0] thresh;
  logic cmp_pulse;

  assign cmp_pulse = strobe_s & ~strobe_dly;
  // holdover uses its own count, zero treated as one
  assign thresh = (state == PHO_HOLD) ? hold_count : run_count; // R14
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_cnt <= '0;
      lock_raw <= 1'b0;
    end else if (enter_hold) begin
      lock_cnt <= '0;
      lock_raw <= 1'b0;
    end else if (cmp_pulse) begin // R11
      if (perr_s < lock_window) begin // R15
        if (lock_cnt + LCNT_W'(1) >= thresh) begin // R18
          lock_raw <= 1'b1;
        end else begin
          lock_cnt <= lock_cnt + LCNT_W'(1);
        end
      end else begin
        lock_cnt <= '0; // R18
        lock_raw <= 1'b0;
      end
    end
  end

  // ==========================================
  // holdover state
  // entry needs enable from the host and a lost reference
  assign enter_hold = state == PHO_TRACK && ctrl.hold_en && !ref_s; // R1 R19
  assign leave_hold = state == PHO_HOLD &&
                      (manual_exit || !ctrl.hold_en ||
                       (ctrl.auto_exit && ref_s && lock_raw)); // R13 R14

  always_comb begin
    next_state = state;
    case (state)
      PHO_TRACK: if (enter_hold) next_state = PHO_HOLD;
      PHO_HOLD: if (leave_hold) next_state = PHO_TRACK;
      default: next_state = PHO_TRACK;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= PHO_TRACK;
    end else begin
      state <= next_state;
    end
  end

  // capture at entry: code to hold and second loop lock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held_code <= '0;
      lock2_held <= 1'b0;
    end else if (enter_hold) begin
      held_code <= ctrl.fixed_sel ? fixed_code : tracker_code; // R16
      lock2_held <= lock2_s; // R9
    end
  end

  // ==========================================
  // loop outputs
  logic hold_n;
  logic lock1_n;
  logic lock2_n;
  logic [DAC_W-1:0] tune_n;

  assign hold_n = next_state == PHO_HOLD;
  assign lock1_n = lock_raw && !hold_n; // R8
  assign lock2_n = (hold_n && !enter_hold && lock2_held) || lock2_s; // R9
  // fixed code stays live so software can retune in holdover
  assign tune_n = !hold_n ? tracker_code :
                  ctrl.fixed_sel ? fixed_code : // R10
                  enter_hold ? tracker_code : held_code; // R2

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cp_drive_en <= 1'b0;
      o_dac_drive_en <= 1'b0;
      o_first_loop_tuning_output <= '0;
      o_holdover <= 1'b0;
      o_first_loop_lock <= 1'b0;
      o_second_loop_lock <= 1'b0;
      o_tracker_acquired <= 1'b0;
    end else begin
      o_cp_drive_en <= !hold_n; // R7
      o_dac_drive_en <= hold_n;
      o_first_loop_tuning_output <= tune_n;
      o_holdover <= hold_n; // R8
      o_first_loop_lock <= lock1_n;
      o_second_loop_lock <= lock2_n;
      o_tracker_acquired <= tracker_acq; // R3
    end
  end

  // status pins through their selectors
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_pin_one <= 1'b0;
      o_status_pin_two <= 1'b0;
    end else begin
      o_status_pin_one <= pin_source(sel_one, lock1_n, lock2_n, hold_n,
                                     tracker_acq); // R12
      o_status_pin_two <= pin_source(sel_two, lock1_n, lock2_n, hold_n,
                                     tracker_acq); // R3
    end
  end

  // ==========================================
  // interrupt status: set wins over a write-one clear
  pho_irq_t irq_evt;
  pho_irq_t irq_clr;
  pho_irq_t next_irq;
  logic acq_dly;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acq_dly <= 1'b0;
    end else begin
      acq_dly <= tracker_acq;
    end
  end

  assign irq_evt.hold_entry = enter_hold;
  assign irq_evt.hold_exit = leave_hold;
  assign irq_evt.tracker_acq = tracker_acq & ~acq_dly;
  assign irq_evt.lock_lost = o_first_loop_lock & ~lock1_n;
  assign irq_clr = (bus_wr && i_wb_adr == OFS_IRQ) ?
                   pho_irq_t'(wr_word[3:0]) : IRQ_RST;
  assign next_irq = (irq_stat & ~irq_clr) | irq_evt;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat <= IRQ_RST;
      o_irq <= 1'b0;
    end else begin
      irq_stat <= next_irq;
      o_irq <= |(next_irq & irq_mask);
    end
  end

endmodule : pho_holdover_ctrl

/* tb/pho_holdover_ctrl_checker.sv */
/*
  port checker: bus handshake and holdover pins.
  assumes one clock, async active-low reset, bound to the top.
*/
module pho_holdover_ctrl_checker #(
  parameter int DAC_W = pho_pkg::DAC_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_ref_valid,
  input wire logic o_cp_drive_en,
  input wire logic o_dac_drive_en,
  input wire logic [DAC_W-1:0] o_first_loop_tuning_output,
  input wire logic o_first_loop_lock,
  input wire logic o_second_loop_lock,
  input wire logic o_holdover,
  input wire logic o_tracker_acquired
);
  timeunit 1ns;
  timeprecision 1ps;
  import pho_pkg::*;
  // ==========================================
  // clocking and shared sequences
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  // two holdover cycles in a row, clear of a reset release
  sequence s_held;
    o_holdover && $past(o_holdover) && $past(i_rst_b);
  endsequence
  // ==========================================
  // properties
  a_ack_pulse: assert property (
    s_req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a one-cycle pulse after request");
  a_hold_pins: assert property (
    o_holdover |-> !o_cp_drive_en && o_dac_drive_en)
    else $error("pump or dac drive wrong in holdover");
  a_track_pins: assert property (
    $past(i_rst_b) && !o_holdover |-> o_cp_drive_en && !o_dac_drive_en)
    else $error("pump or dac drive wrong outside holdover");
  a_hold_lock1: assert property (
    o_holdover |-> !o_first_loop_lock)
    else $error("first lock shown in holdover");
  a_entry_cause: assert property (
    $rose(o_holdover) |-> !$past(i_ref_valid, 2))
    else $error("holdover entered with valid reference");
  // skip cycles where a bus write may retune the fixed code
  a_tune_frozen: assert property (
    s_held ##0 (!$past(i_wb_cyc) && !$past(i_wb_cyc, 2))
    |-> $stable(o_first_loop_tuning_output))
    else $error("tuning code moved in holdover");
  a_second_held: assert property (
    s_held ##0 $past(o_second_loop_lock) |-> o_second_loop_lock)
    else $error("second lock dropped in holdover");
  a_acq_frozen: assert property (
    s_held |-> $stable(o_tracker_acquired))
    else $error("acquired flag moved in holdover");
  a_tune_slew: assert property (
    $past(i_rst_b) && !o_holdover && !$past(o_holdover)
    |-> o_first_loop_tuning_output + 1 - $past(o_first_loop_tuning_output) <= 2)
    else $error("tracker stepped more than one code");
endmodule : pho_holdover_ctrl_checker

bind pho_holdover_ctrl pho_holdover_ctrl_checker #(.DAC_W(DAC_W)) i_pho_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_ack(o_wb_ack), .i_ref_valid(i_ref_valid), .o_cp_drive_en(o_cp_drive_en),
  .o_dac_drive_en(o_dac_drive_en), .o_first_loop_lock(o_first_loop_lock),
  .o_first_loop_tuning_output(o_first_loop_tuning_output),
  .o_second_loop_lock(o_second_loop_lock), .o_holdover(o_holdover),
  .o_tracker_acquired(o_tracker_acquired));

/* tb/pho_loop_model.sv */
/*
  far-side model: reference monitor, phase comparator and vcxo tuning.
  assumes the bench sets reference, error and target.
*/
module pho_loop_model (
  input wire logic i_clk,
  input wire logic i_ref_ok,
  input wire logic [pho_pkg::PERR_W-1:0] i_err,
  input wire logic [pho_pkg::DAC_W-1:0] i_target,
  input wire logic i_cp_en,
  input wire logic [pho_pkg::DAC_W-1:0] i_dac,
  output logic o_ref_valid,
  output logic o_strobe,
  output logic [pho_pkg::PERR_W-1:0] o_phase_error,
  output logic [pho_pkg::DAC_W-1:0] o_tune_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import pho_pkg::*;
  logic [2:0] phase = 3'h0;
  // one compare every eight clocks
  always_ff @(posedge i_clk) begin
    phase <= phase + 3'h1;
  end
  // error scrambled in the gap so a late sample cannot pass by luck
  assign o_strobe = (phase == 3'h1) || (phase == 3'h2);
  assign o_phase_error = (phase == 3'h7) ? ~i_err : i_err;
  // open loop: the vcxo follows the dac once the pump lets go
  assign o_tune_code = i_cp_en ? i_target : i_dac;
  assign o_ref_valid = i_ref_ok;
endmodule : pho_loop_model

/* tb/pho_holdover_ctrl_test.sv */
/*
  self-checking bench for the holdover controller.
  assumes the package register map.
*/
module pho_holdover_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pho_pkg::*;
  logic i_clk, i_rst_b, cyc, stb, we, ack, ref_ok, lock2, ref_v, strobe;
  logic cp_en, dac_en, pin1, pin2, lock1, lock2_o, hold, acq, irq;
  logic [7:0] adr, err, perr;
  logic [31:0] wdat, rd, o_wb_dat;
  logic [3:0] sel;
  logic [9:0] target, fixed, dac, tune;
  logic [39:0] rst_tab [9];
  int n_errors, cmp_count, seed, k, g;
  // ==========================================
  // design and far side
  pho_holdover_ctrl i_pho_holdover_ctrl (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(o_wb_dat), .o_wb_ack(ack),
    .i_ref_valid(ref_v), .i_compare_strobe(strobe), .i_phase_error(perr),
    .i_second_loop_lock(lock2), .i_tune_code(tune), .o_cp_drive_en(cp_en),
    .o_dac_drive_en(dac_en), .o_first_loop_tuning_output(dac), .o_status_pin_one(pin1),
    .o_status_pin_two(pin2), .o_first_loop_lock(lock1), .o_second_loop_lock(lock2_o),
    .o_holdover(hold), .o_tracker_acquired(acq), .o_irq(irq));
  pho_loop_model i_pho_loop_model (.i_clk(i_clk), .i_ref_ok(ref_ok), .i_err(err),
    .i_target(target), .i_cp_en(cp_en), .i_dac(dac), .o_ref_valid(ref_v),
    .o_strobe(strobe), .o_phase_error(perr), .o_tune_code(tune));
  // ==========================================
  // clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    #(40000 * 50);
    n_errors++;
    close_out();
  end
  // ==========================================
  // compare, bus and verdict helpers
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_b
  // request held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) n_errors++;
    rd = o_wb_dat;
    {cyc, stb} <= 2'h0;
    @(posedge i_clk);
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk_w(rd, exp);
  endtask : rdc
  task automatic wait_hold(input logic v);
    for (int n = 0; n < 200 && hold !== v; n++) begin
      @(posedge i_clk);
    end
    chk_b(hold, v);
  endtask : wait_hold
  // cycles until the tuning code next moves
  task automatic step_gap(output int gap);
    logic [9:0] was;
    was = dac;
    for (gap = 0; dac === was && gap < 500; gap++) begin
      @(posedge i_clk);
    end
  endtask : step_gap
  function automatic logic pin_exp(input int s, input logic l1, l2, h, a);
    logic [7:0] t;
    t = {2'h0, a, h, l1 & l2, l2, l1, 1'b0};
    return t[s];
  endfunction : pin_exp
  task automatic close_out();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // ==========================================
  // main sequence
  initial begin
    seed = 97;
    n_errors = 0;
    cmp_count = 0;
    i_rst_b = 1'b0;
    {cyc, stb, we, adr, wdat, sel} = '0;
    {ref_ok, lock2, err} = {2'h3, 8'h30};
    target = 10'h028 + 10'($unsigned($random(seed)) % 64);
    fixed = target ^ {1'b1, 9'($random(seed))};
    rst_tab = '{{OFS_CTRL, 32'h0}, {OFS_FIXED, 32'h0}, {OFS_SELECT, 32'h0},
      {OFS_RATE, {8'h0, CNTR_RST, 1'b0, MULT_RST}}, {OFS_WINDOW, {24'h0, WINDOW_RST}},
      {OFS_COUNT, {2'h0, LCNT_RST, 2'h0, LCNT_RST}}, {OFS_IRQ, 32'h0},
      {OFS_MASK, 32'h0}, {8'h40, 32'h0}};
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    // reset values, unmapped read, unselected byte lanes
    foreach (rst_tab[k]) begin
      rdc(rst_tab[k][39:32], rst_tab[k][31:0]);
    end
    sel <= 4'h2;
    wb(1'b1, OFS_MASK, 32'hFFFF_FFFF);
    sel <= 4'hF;
    rdc(OFS_MASK, 32'h0);
    wb(1'b1, OFS_MASK, 32'hF);
    wb(1'b1, OFS_RATE, {8'h0, 8'h05, 16'h0004});
    wb(1'b1, OFS_SELECT, {21'h0, SEL_ACQ, 5'h0, SEL_HOLD});
    wb(1'b1, OFS_CTRL, 32'h3);
    step_gap(g);
    step_gap(g);
    chk_w(g, 32'h14);
    for (k = 0; k < 4000 && acq !== 1'b1; k++) begin
      @(posedge i_clk);
    end
    chk_b(pin2, 1'b1);
    repeat (80) @(posedge i_clk);
    // tracked holdover entry on reference loss
    ref_ok <= 1'b0;
    wait_hold(1'b1);
    chk_b(cp_en, 1'b0);
    chk_b(lock1, 1'b0);
    chk_w(dac, target);
    lock2 <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk_b(lock2_o, 1'b1);
    chk_b(irq, 1'b1);
    rdc(OFS_STATUS, {6'h0, target, 16'h001D});
    for (k = 0; k < 8; k++) begin
      wb(1'b1, OFS_SELECT, 32'(k));
      repeat (2) @(posedge i_clk);
      chk_b(pin1, pin_exp(k, 1'b0, 1'b1, 1'b1, 1'b1));
    end
    wb(1'b1, OFS_IRQ, 32'hF);
    rdc(OFS_IRQ, 32'h0);
    chk_b(irq, 1'b0);
    // manual exit, then fixed code overrides the tracked one
    {lock2, ref_ok} <= 2'h3;
    repeat (4) @(posedge i_clk);
    wb(1'b1, OFS_CTRL, 32'hB);
    wait_hold(1'b0);
    rdc(OFS_CTRL, 32'h3);
    wb(1'b1, OFS_FIXED, {22'h0, fixed});
    wb(1'b1, OFS_CTRL, 32'h7);
    ref_ok <= 1'b0;
    wait_hold(1'b1);
    chk_w(dac, fixed);
    ref_ok <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'hF);
    wait_hold(1'b0);
    // automatic exit: error on the window edge must not count
    wb(1'b1, OFS_COUNT, {2'h0, 14'h0003, 2'h0, 14'h0006});
    wb(1'b1, OFS_CTRL, 32'h13);
    {ref_ok, err} <= {1'b0, 8'h10};
    wait_hold(1'b1);
    ref_ok <= 1'b1;
    repeat (80) @(posedge i_clk);
    chk_b(hold, 1'b1);
    err <= 8'h0F;
    wait_hold(1'b0);
    repeat (60) @(posedge i_clk);
    chk_b(lock1, 1'b1);
    err <= 8'h40;
    repeat (24) @(posedge i_clk);
    chk_b(lock1, 1'b0);
    wb(1'b1, OFS_MASK, 32'h0);
    repeat (2) @(posedge i_clk);
    chk_b(irq, 1'b0);
    wb(1'b1, OFS_MASK, 32'h8);
    repeat (2) @(posedge i_clk);
    chk_b(irq, 1'b1);
    close_out();
  end
endmodule : pho_holdover_ctrl_test
